/* imu_user_register_bank.v */
// user register bank of a six-axis inertial sensor, reached over a four-wire serial slave port
// assumes: sensor_data and status_in come from logic on clk_sys; pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "imu_regs_defs.vh"

module imu_user_register_bank #(
  parameter [15:0] BATCH_LOW_ID = 16'h0A11, // arbitrary value
  parameter [15:0] BATCH_HIGH_ID = 16'h0B22, // arbitrary value
  parameter [15:0] PRODUCT_ID = 16'h1234, // arbitrary value
  parameter [15:0] UNIT_SEQ_ID = 16'h0C33, // arbitrary value
  parameter integer BACKUP_CYCLES = `BACKUP_CYCLES_DEF // backup duration in clk_sys cycles
) (
  input wire clk_sys, // system clock, 100 MHz
  input wire rst, // synchronous reset, active high
  input wire power_on, // power-up reset of the store, active high
  input wire spi_sclk, // serial clock pin
  input wire spi_cs_n, // chip select pin, active low
  input wire spi_din, // serial data in pin
  output wire spi_dout, // serial data out pin
  input wire [111:0] sensor_data, // rate x,y,z, accel x,y,z, temperature, low word first
  input wire [15:0] status_in, // status flags from the sensing logic
  input wire aux_pin_a_in, // auxiliary pin a level
  output reg aux_pin_a_out, // auxiliary pin a drive value
  output reg aux_pin_a_oe, // auxiliary pin a drive enable
  input wire aux_pin_b_in, // auxiliary pin b level
  output reg aux_pin_b_out, // auxiliary pin b drive value
  output reg aux_pin_b_oe, // auxiliary pin b drive enable
  input wire aux_pin_c_in, // auxiliary pin c level
  output reg aux_pin_c_out, // auxiliary pin c drive value
  output reg aux_pin_c_oe, // auxiliary pin c drive enable
  input wire aux_pin_d_sync_input_in, // auxiliary pin d level or sync clock
  output reg aux_pin_d_sync_input_out, // auxiliary pin d drive value
  output reg aux_pin_d_sync_input_oe, // auxiliary pin d drive enable
  output reg sync_mode, // external sync clock selected
  output reg sample_strobe, // one-cycle pulse per sync clock rising edge
  output reg backup_busy, // nonvolatile backup in progress
  output reg [`NV_BITS-1:0] config_image // backed-up configuration, slot 0 low
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  wire [15:0] rx_word;
  wire rx_valid;
  wire [`NV_BITS-1:0] nv_image;
  wire [15:0] write_count;
  wire nv_busy;
  reg [15:0] tx_word;
  reg [15:0] read_word;
  reg [15:0] aux_io_control;
  reg backup_start;
  reg [3:0] aux_s1;
  reg [3:0] aux_s2;
  reg pin_d_prev;
  reg [3:0] eff_dir;
  reg [3:0] aux_level;

  wire [6:0] addr = rx_word[14:8];
  wire [6:0] word_addr = {addr[6:1], 1'b0};
  wire upper = addr[0];
  wire [7:0] wbyte = rx_word[7:0];
  wire [3:0] slot = nv_slot(word_addr);
  wire [7:0] slot_base = {slot, 4'h0};
  wire [15:0] sample_period = config_image[7*16 +: 16];

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function [3:0] nv_slot;
    input [6:0] a;
    begin
      case (a)
        `A_RATE_X_BIAS: nv_slot = 4'h0;
        `A_RATE_Y_BIAS: nv_slot = 4'h1;
        `A_RATE_Z_BIAS: nv_slot = 4'h2;
        `A_ACCEL_X_BIAS: nv_slot = 4'h3;
        `A_ACCEL_Y_BIAS: nv_slot = 4'h4;
        `A_ACCEL_Z_BIAS: nv_slot = 4'h5;
        `A_MISC_CTRL: nv_slot = 4'h6;
        `A_SAMPLE_PERIOD: nv_slot = 4'h7;
        `A_RANGE_FILTER: nv_slot = 4'h8;
        `A_ALARM1_THR: nv_slot = 4'h9;
        `A_ALARM2_THR: nv_slot = 4'hA;
        `A_ALARM1_SIZE: nv_slot = 4'hB;
        `A_ALARM2_SIZE: nv_slot = 4'hC;
        `A_ALARM_CTRL: nv_slot = 4'hD;
        default: nv_slot = `SLOT_NONE;
      endcase
    end
  endfunction

  // byte write into one half of a 16-bit register
  function [15:0] merge_byte;
    input [15:0] old;
    input hi;
    input [7:0] b;
    begin
      if (hi) begin
        merge_byte = {b, old[7:0]};
      end else begin
        merge_byte = {old[15:8], b};
      end
    end
  endfunction

  // ----------------------------------------
  // serial port and nonvolatile store
  // ----------------------------------------
  spi_frame u_spi (
    .clk_sys(clk_sys),
    .rst(rst),
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .din(spi_din),
    .tx_word(tx_word),
    .dout(spi_dout),
    .rx_word(rx_word),
    .rx_valid(rx_valid)
  );

  nv_store #(
    .BACKUP_CYCLES(BACKUP_CYCLES)
  ) u_nv (
    .clk_sys(clk_sys),
    .power_on(power_on),
    .backup_start(backup_start),
    .image_in(config_image),
    .image_out(nv_image),
    .write_count(write_count),
    .busy(nv_busy)
  );

  // ----------------------------------------
  // auxiliary pins
  // ----------------------------------------
  always @* begin
    eff_dir = aux_io_control[`AUX_DIR_LSB +: 4];
    // in sync mode pin d is an input whatever the direction bit says
    if (sync_mode) begin
      eff_dir[`PIN_D] = 1'b0;
    end
    aux_level = (aux_io_control[`AUX_LVL_LSB +: 4] & eff_dir) | (aux_s2 & ~eff_dir);
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      aux_s1 <= 4'h0;
      aux_s2 <= 4'h0;
      pin_d_prev <= 1'b0;
      sync_mode <= 1'b0;
      sample_strobe <= 1'b0;
      backup_busy <= 1'b0;
      {aux_pin_a_oe, aux_pin_b_oe, aux_pin_c_oe, aux_pin_d_sync_input_oe} <= 4'h0;
      {aux_pin_a_out, aux_pin_b_out, aux_pin_c_out, aux_pin_d_sync_input_out} <= 4'h0;
    end else begin
      aux_s1 <= {aux_pin_d_sync_input_in, aux_pin_c_in, aux_pin_b_in, aux_pin_a_in};
      aux_s2 <= aux_s1;
      pin_d_prev <= aux_s2[`PIN_D];
      sync_mode <= ~sample_period[`SYNC_SEL_BIT];
      sample_strobe <= sync_mode & aux_s2[`PIN_D] & ~pin_d_prev;
      backup_busy <= nv_busy;
      aux_pin_a_oe <= eff_dir[0];
      aux_pin_b_oe <= eff_dir[1];
      aux_pin_c_oe <= eff_dir[2];
      aux_pin_d_sync_input_oe <= eff_dir[`PIN_D];
      aux_pin_a_out <= aux_io_control[`AUX_LVL_LSB] & eff_dir[0];
      aux_pin_b_out <= aux_io_control[`AUX_LVL_LSB + 1] & eff_dir[1];
      aux_pin_c_out <= aux_io_control[`AUX_LVL_LSB + 2] & eff_dir[2];
      aux_pin_d_sync_input_out <= aux_io_control[`AUX_LVL_LSB + 3] & eff_dir[`PIN_D];
    end
  end

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  always @* begin
    case (word_addr)
      `A_WRITE_COUNT: read_word = write_count;
      `A_RATE_X: read_word = sensor_data[0 +: 16];
      `A_RATE_Y: read_word = sensor_data[16 +: 16];
      `A_RATE_Z: read_word = sensor_data[32 +: 16];
      `A_ACCEL_X: read_word = sensor_data[48 +: 16];
      `A_ACCEL_Y: read_word = sensor_data[64 +: 16];
      `A_ACCEL_Z: read_word = sensor_data[80 +: 16];
      `A_TEMP: read_word = sensor_data[96 +: 16];
      `A_AUX_CTRL: read_word = {aux_io_control[15:8], aux_level, aux_io_control[3:0]};
      `A_STATUS: begin
        read_word = status_in;
        read_word[`STAT_NV_BUSY_BIT] = status_in[`STAT_NV_BUSY_BIT] | nv_busy;
      end
      `A_BATCH_LOW: read_word = BATCH_LOW_ID;
      `A_BATCH_HIGH: read_word = BATCH_HIGH_ID;
      `A_PRODUCT: read_word = PRODUCT_ID;
      `A_UNIT_SEQ: read_word = UNIT_SEQ_ID;
      default: begin
        // backed-up slots, else reserved or write-only reads as zero
        if (slot != `SLOT_NONE) begin
          read_word = config_image[slot_base +: 16];
        end else begin
          read_word = 16'h0000;
        end
      end
    endcase
  end

  // ----------------------------------------
  // frame handling and register writes
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      // reload from the store; while the store itself is being cleared use defaults directly
      if (power_on) begin
        config_image <= `NV_DEFAULTS;
      end else begin
        config_image <= nv_image;
      end
      aux_io_control <= 16'h0000;
      tx_word <= 16'h0000;
      backup_start <= 1'b0;
    end else begin
      backup_start <= 1'b0;
      if (rx_valid) begin
        if (rx_word[`RW_BIT]) begin
          // answer to a write frame is not defined; send zero
          tx_word <= 16'h0000;
          if (slot != `SLOT_NONE) begin
            config_image[slot_base +: 16] <= merge_byte(config_image[slot_base +: 16], upper, wbyte);
          end else if (word_addr == `A_AUX_CTRL) begin
            aux_io_control <= merge_byte(aux_io_control, upper, wbyte);
          end else if (word_addr == `A_COMMAND && !upper && wbyte[`CMD_BACKUP_BIT] && !nv_busy) begin
            backup_start <= 1'b1;
          end
          // every other address falls through untouched
        end else begin
          tx_word <= read_word;
        end
      end
    end
  end

endmodule // imu_user_register_bank
`default_nettype wire

/* imu_regs_defs.vh */
// register map, field positions and timing constants of the inertial sensor register bank
// assumes: included by its bare name from every design file of the bank
`ifndef IMU_REGS_DEFS_VH
`define IMU_REGS_DEFS_VH

// ----------------------------------------
// serial frame
// ----------------------------------------
`define FRAME_BITS 16
`define FRAME_LAST 5'h0F
`define RW_BIT 15

// ----------------------------------------
// register byte addresses (lower byte)
// ----------------------------------------
`define A_WRITE_COUNT 7'h00
`define A_RATE_X 7'h04
`define A_RATE_Y 7'h06
`define A_RATE_Z 7'h08
`define A_ACCEL_X 7'h0A
`define A_ACCEL_Y 7'h0C
`define A_ACCEL_Z 7'h0E
`define A_TEMP 7'h18
`define A_RATE_X_BIAS 7'h1A
`define A_RATE_Y_BIAS 7'h1C
`define A_RATE_Z_BIAS 7'h1E
`define A_ACCEL_X_BIAS 7'h20
`define A_ACCEL_Y_BIAS 7'h22
`define A_ACCEL_Z_BIAS 7'h24
`define A_AUX_CTRL 7'h32
`define A_MISC_CTRL 7'h34
`define A_SAMPLE_PERIOD 7'h36
`define A_RANGE_FILTER 7'h38
`define A_STATUS 7'h3C
`define A_COMMAND 7'h3E
`define A_ALARM1_THR 7'h40
`define A_ALARM2_THR 7'h42
`define A_ALARM1_SIZE 7'h44
`define A_ALARM2_SIZE 7'h46
`define A_ALARM_CTRL 7'h48
`define A_BATCH_LOW 7'h52
`define A_BATCH_HIGH 7'h54
`define A_PRODUCT 7'h56
`define A_UNIT_SEQ 7'h58

// ----------------------------------------
// backed-up configuration image: 14 slots of 16 bits, slot 0 in the low bits
// ----------------------------------------
`define NV_SLOTS 14
`define NV_BITS 224
`define SLOT_NONE 4'hF
`define NV_DEFAULTS {80'h0, 16'h0402, 16'h0001, 16'h0006, 96'h0}

// ----------------------------------------
// fields
// ----------------------------------------
`define CMD_BACKUP_BIT 3
`define SYNC_SEL_BIT 0
`define AUX_DIR_LSB 0
`define AUX_LVL_LSB 4
`define STAT_NV_BUSY_BIT 7
`define PIN_D 3

// ----------------------------------------
// timing
// ----------------------------------------
`define BACKUP_TIME_MS 75
`define CLK_FREQ_KHZ 100000
`define BACKUP_CYCLES_DEF (`BACKUP_TIME_MS * `CLK_FREQ_KHZ)

`endif

/* spi_frame.v */
// serial slave shifter: 16-bit frames, clock idle high, most significant bit first
// assumes: pins are asynchronous to clk_sys; serial clock well below a quarter of clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "imu_regs_defs.vh"

module spi_frame (
  input wire clk_sys, // system clock
  input wire rst, // synchronous reset, active high
  input wire sclk, // serial clock pin
  input wire cs_n, // chip select pin, active low
  input wire din, // serial data in pin
  input wire [15:0] tx_word, // word shifted out in the next frame
  output reg dout, // serial data out
  output reg [15:0] rx_word, // last received frame
  output reg rx_valid // one-cycle pulse per received frame
);

  reg [2:0] sclk_s;
  reg [1:0] cs_s;
  reg [1:0] din_s;
  reg [14:0] sh_out;
  reg [14:0] sh_in;
  reg [4:0] cnt;
  wire rise = sclk_s[1] & ~sclk_s[2];
  wire fall = ~sclk_s[1] & sclk_s[2];

  // ----------------------------------------
  // synchronisers and shifting
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      sclk_s <= 3'h7;
      cs_s <= 2'h3;
      din_s <= 2'h0;
      sh_out <= 15'h0000;
      sh_in <= 15'h0000;
      cnt <= 5'h00;
      dout <= 1'b0;
      rx_word <= 16'h0000;
      rx_valid <= 1'b0;
    end else begin
      sclk_s <= {sclk_s[1:0], sclk};
      cs_s <= {cs_s[0], cs_n};
      din_s <= {din_s[0], din};
      rx_valid <= 1'b0;
      if (cs_s[1]) begin
        cnt <= 5'h00;
      end else begin
        if (fall) begin
          // reloading on the first fall also covers frames that follow without a chip select gap
          if (cnt == 5'h00) begin
            dout <= tx_word[15];
            sh_out <= tx_word[14:0];
          end else begin
            dout <= sh_out[14];
            sh_out <= {sh_out[13:0], 1'b0};
          end
        end
        if (rise) begin
          sh_in <= {sh_in[13:0], din_s[1]};
          if (cnt == `FRAME_LAST) begin
            rx_word <= {sh_in, din_s[1]};
            rx_valid <= 1'b1;
            cnt <= 5'h00;
          end else begin
            cnt <= cnt + 5'h01;
          end
        end
      end
    end
  end

endmodule // spi_frame
`default_nettype wire

/* nv_store.v */
// nonvolatile mirror of the configuration image and its write counter
// assumes: power_on is asserted once at power-up; rst of the bank does not touch this store
`timescale 1ns/1ps
`default_nettype none
`include "imu_regs_defs.vh"

module nv_store #(
  parameter integer BACKUP_CYCLES = `BACKUP_CYCLES_DEF
) (
  input wire clk_sys, // system clock
  input wire power_on, // power-up clear, active high
  input wire backup_start, // one-cycle request to copy image_in
  input wire [`NV_BITS-1:0] image_in, // volatile configuration
  output reg [`NV_BITS-1:0] image_out, // stored configuration
  output reg [15:0] write_count, // completed backups
  output reg busy // backup in progress
);

  // the cut to the timer width is deliberate
  localparam integer LOAD_FULL = BACKUP_CYCLES - 1;
  localparam [23:0] LOAD = LOAD_FULL[23:0];
  reg [23:0] timer;

  always @(posedge clk_sys) begin
    if (power_on) begin
      image_out <= `NV_DEFAULTS;
      write_count <= 16'h0000;
      busy <= 1'b0;
      timer <= 24'h000000;
    end else if (backup_start && !busy) begin
      image_out <= image_in;
      busy <= 1'b1;
      timer <= LOAD;
    end else if (busy) begin
      if (timer == 24'h000000) begin
        busy <= 1'b0;
        write_count <= write_count + 16'h0001;
      end else begin
        timer <= timer - 24'h000001;
      end
    end
  end

endmodule // nv_store
`default_nettype wire

/* imu_regs_checker_properties.sv */
// port-level checks of the inertial sensor register bank
// assumes: bound to imu_user_register_bank; serial clock half period at least 8 system cycles
`timescale 1ns/1ps
`default_nettype none
module imu_regs_checker #(
  parameter integer BACKUP_CYCLES = 40
) (
  input wire clk_sys, // system clock
  input wire rst, // synchronous reset
  input wire power_on, // store clear
  input wire spi_sclk, // serial clock pin
  input wire spi_dout, // serial data out
  input wire aux_pin_a_out, // pin a drive value
  input wire aux_pin_a_oe, // pin a drive enable
  input wire aux_pin_d_sync_input_in, // pin d level
  input wire aux_pin_d_sync_input_oe, // pin d drive enable
  input wire sync_mode, // sync clock selected
  input wire sample_strobe, // sync pulse
  input wire backup_busy, // backup running
  input wire [223:0] config_image // backed-up registers
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  reg sclk_q, pin_q;
  reg [3:0] since_fall, since_rise, since_pin;
  integer busy_len;
  // counters saturate so long idle spells never wrap into a false match
  always @(posedge clk_sys) begin
    sclk_q <= spi_sclk;
    pin_q <= aux_pin_d_sync_input_in;
    since_fall <= (sclk_q && !spi_sclk) ? 4'h0 : since_fall + {3'h0, since_fall != 4'hF};
    since_rise <= (!sclk_q && spi_sclk) ? 4'h0 : since_rise + {3'h0, since_rise != 4'hF};
    since_pin <= (!pin_q && aux_pin_d_sync_input_in) ? 4'h0 : since_pin + {3'h0, since_pin != 4'hF};
    busy_len <= backup_busy ? busy_len + 1 : 0;
    if (rst) begin
      since_fall <= 4'hF;
      since_rise <= 4'hF;
      since_pin <= 4'hF;
      busy_len <= 0;
    end
  end
  sequence backup_run;
    backup_busy [*8];
  endsequence
  dout_fall_a: assert property ($changed(spi_dout) |-> since_fall <= 4'h7)
    else $error("data out moved away from a clock fall");
  backup_start_a: assert property ($rose(backup_busy) |-> (since_rise <= 4'hC) ##0 backup_run)
    else $error("backup started without a frame");
  backup_len_a: assert property ($fell(backup_busy) |-> busy_len >= BACKUP_CYCLES && busy_len <= BACKUP_CYCLES + 1)
    else $error("backup length wrong");
  image_hold_a: assert property ($changed(config_image) |-> since_rise <= 4'hC)
    else $error("configuration moved outside a frame");
  nv_default_a: assert property ($fell(rst) && $past(power_on) |->
    config_image[127:96] == 32'h0001_0006 && config_image[143:128] == 16'h0402)
    else $error("power-up defaults wrong");
  aux_gate_a: assert property (!aux_pin_a_oe |-> !aux_pin_a_out)
    else $error("pin a driven while input");
  sync_pin_a: assert property (sync_mode && $past(sync_mode) |-> !aux_pin_d_sync_input_oe)
    else $error("pin d driven in sync mode");
  strobe_pulse_a: assert property (sample_strobe |=> !sample_strobe)
    else $error("strobe longer than one cycle");
  strobe_cause_a: assert property (sample_strobe |-> since_pin <= 4'h6 && $past(sync_mode))
    else $error("strobe without sync edge");
  sync_sel_a: assert property ((!config_image[112]) [*3] |-> sync_mode)
    else $error("sync mode not selected");
  sync_off_a: assert property (config_image[112] [*3] |-> !sync_mode)
    else $error("sync mode wrongly selected");
endmodule // imu_regs_checker
`default_nettype wire

/* spi_host_model.sv */
// host side of the serial port: mode 3 master, 16-bit frames, msb first
// assumes: runs on clk_sys; 8 system cycles per half period gives the 160 ns serial clock
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire clk_sys, // system clock
  input wire dout, // device data out
  output logic sclk, // serial clock, idle high
  output logic cs_n, // chip select, active low
  output logic din // serial data in
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b1;
  end
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    integer i;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    for (i = 15; i >= 0; i--) begin
      sclk <= 1'b0;
      din <= tx[i];
      repeat (8) @(posedge clk_sys);
      sclk <= 1'b1;
      rx[i] = dout;
      repeat (8) @(posedge clk_sys);
    end
    cs_n <= 1'b1;
    // released line shows the inverse so a stale bit is never mistaken for data
    din <= ~tx[0];
    repeat (16) @(posedge clk_sys);
  endtask
endmodule // spi_host_model
`default_nettype wire

/* imu_user_register_bank_tb.sv */
// self-checking bench of the register bank through its serial port
// assumes: spi_host_model drives the pins; backup shortened to 40 cycles
`timescale 1ns/1ps
`default_nettype none
module imu_user_register_bank_tb;
  logic clk_sys, rst, power_on, spi_sclk, spi_cs_n, spi_din, spi_dout;
  logic sync_mode, sample_strobe, backup_busy;
  logic [111:0] sensor_data;
  logic [15:0] status_in, strobes;
  logic [3:0] pin_in, pin_out, pin_oe;
  logic [223:0] config_image;
  logic [6:0] rw_a [0:13] = '{7'h1A, 7'h1C, 7'h1E, 7'h20, 7'h22, 7'h24, 7'h34, 7'h36, 7'h38, 7'h40,
    7'h42, 7'h44, 7'h46, 7'h48};
  integer fails = 0;
  integer samples_checked = 0;
  imu_user_register_bank #(.BACKUP_CYCLES(40)) i_imu_user_register_bank (.clk_sys(clk_sys), .rst(rst),
    .power_on(power_on), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_din(spi_din), .spi_dout(spi_dout),
    .sensor_data(sensor_data), .status_in(status_in), .aux_pin_a_in(pin_in[0]), .aux_pin_a_out(pin_out[0]),
    .aux_pin_a_oe(pin_oe[0]), .aux_pin_b_in(pin_in[1]), .aux_pin_b_out(pin_out[1]), .aux_pin_b_oe(pin_oe[1]),
    .aux_pin_c_in(pin_in[2]), .aux_pin_c_out(pin_out[2]), .aux_pin_c_oe(pin_oe[2]),
    .aux_pin_d_sync_input_in(pin_in[3]), .aux_pin_d_sync_input_out(pin_out[3]),
    .aux_pin_d_sync_input_oe(pin_oe[3]), .sync_mode(sync_mode), .sample_strobe(sample_strobe),
    .backup_busy(backup_busy), .config_image(config_image));
  spi_host_model i_spi_host_model (.clk_sys(clk_sys), .dout(spi_dout), .sclk(spi_sclk), .cs_n(spi_cs_n),
    .din(spi_din));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (sample_strobe === 1'b1) strobes <= strobes + 16'h0001;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    i_spi_host_model.xfer({1'b1, a, d}, r);
  endtask
  // a read costs two frames: the answer rides on the following one
  task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] r;
    i_spi_host_model.xfer({1'b0, a, 8'h00}, r);
    i_spi_host_model.xfer(16'h0000, r);
    chk($sformatf("reg %h", a), exp, r);
  endtask
  task automatic do_reset(input logic por);
    @(posedge clk_sys);
    rst <= 1'b1;
    power_on <= por;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    power_on <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  function automatic logic [15:0] dflt(input integer i);
    dflt = (i == 6) ? 16'h0006 : (i == 7) ? 16'h0001 : (i == 8) ? 16'h0402 : 16'h0000;
  endfunction
  initial begin
    integer i;
    rst = 1'b1;
    power_on = 1'b1;
    status_in = 16'h0000;
    pin_in = 4'h0;
    strobes = 16'h0000;
    sensor_data = 112'h7007_6006_5005_4004_3003_2002_1001;
    do_reset(1'b1);
    for (i = 0; i < 14; i++) rchk(rw_a[i], dflt(i));
    rchk(7'h32, 16'h0000);
    rchk(7'h00, 16'h0000);
    rchk(7'h56, 16'h1234);
    $display("test defaults done");
    wr(7'h04, 8'hFF);
    wr(7'h05, 8'hFF);
    wr(7'h10, 8'h55);
    wr(7'h3F, 8'hFF);
    chk("busy", 16'h0000, {15'h0000, backup_busy});
    for (i = 0; i < 14; i++) chk("image", dflt(i), config_image[16*i+:16]);
    rchk(7'h00, 16'h0000);
    status_in <= 16'h0105;
    for (i = 0; i < 6; i++) rchk(7'h04 + 2 * i, 16'h1001 * (i + 1));
    rchk(7'h18, 16'h7007);
    rchk(7'h07, 16'h2002);
    rchk(7'h10, 16'h0000);
    rchk(7'h3E, 16'h0000);
    rchk(7'h3C, 16'h0105);
    $display("test read-only done");
    for (i = 0; i < 14; i++) begin
      wr(rw_a[i], 8'hA0 + i[7:0]);
      wr(rw_a[i] + 7'h01, 8'h50 + i[7:0]);
    end
    for (i = 0; i < 14; i++) begin
      rchk(rw_a[i], {8'h50 + i[7:0], 8'hA0 + i[7:0]});
      chk("image", {8'h50 + i[7:0], 8'hA0 + i[7:0]}, config_image[16*i+:16]);
    end
    $display("test byte writes done");
    pin_in <= 4'hC;
    wr(7'h32, 8'h53);
    chk("oe", 16'h0003, {12'h000, pin_oe});
    chk("out", 16'h0001, {12'h000, pin_out});
    rchk(7'h32, 16'h00D3);
    chk("strobes", 16'h0000, strobes);
    $display("test aux pins done");
    wr(7'h3E, 8'h08);
    chk("busy", 16'h0001, {15'h0000, backup_busy});
    for (i = 0; i < 100 && backup_busy !== 1'b0; i++) @(posedge clk_sys);
    chk("busy end", 16'h0000, {15'h0000, backup_busy});
    rchk(7'h00, 16'h0001);
    wr(7'h1A, 8'h11);
    do_reset(1'b0);
    rchk(7'h1A, 16'h50A0);
    // aux control is not backed up, so reset cleared it; bits 7:6 of inputs c and d still show the pin levels
    rchk(7'h32, 16'h00C0);
    rchk(7'h00, 16'h0001);
    $display("test backup done");
    wr(7'h32, 8'h08);
    wr(7'h36, 8'hA6);
    chk("sync", 16'h0001, {15'h0000, sync_mode});
    chk("oe", 16'h0000, {12'h000, pin_oe});
    for (i = 0; i < 3; i++) begin
      pin_in[3] <= 1'b0;
      repeat (10) @(posedge clk_sys);
      pin_in[3] <= 1'b1;
      repeat (10) @(posedge clk_sys);
    end
    chk("strobes", 16'h0003, strobes);
    $display("test sync done");
    summarize();
  end
endmodule // imu_user_register_bank_tb
bind imu_user_register_bank imu_regs_checker #(.BACKUP_CYCLES(BACKUP_CYCLES)) i_imu_regs_checker (
  .clk_sys(clk_sys), .rst(rst), .power_on(power_on), .spi_sclk(spi_sclk), .spi_dout(spi_dout),
  .aux_pin_a_out(aux_pin_a_out), .aux_pin_a_oe(aux_pin_a_oe), .aux_pin_d_sync_input_in(aux_pin_d_sync_input_in),
  .aux_pin_d_sync_input_oe(aux_pin_d_sync_input_oe), .sync_mode(sync_mode), .sample_strobe(sample_strobe),
  .backup_busy(backup_busy), .config_image(config_image));
`default_nettype wire
